/* ots_pkg.sv */
package ots_pkg;

   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int          OTS_NUM_TERM   = 5;
   localparam int          OTS_CODE_W     = 5;
   localparam int          OTS_NUM_COND   = 19;
   localparam int          OTS_ADR_W      = 8;
   localparam int          OTS_DAT_W      = 32;
   localparam int          OTS_AIN_W      = 12;
   localparam int          OTS_PULSE_W    = 25;

   // ------------------------------------------------------------
   // Selection codes
   // ------------------------------------------------------------
   localparam logic [4:0]  OTS_SEL_NONE       = 5'h00;
   localparam logic [4:0]  OTS_SEL_RUNNING    = 5'h01;
   localparam logic [4:0]  OTS_SEL_FAULT_STOP = 5'h02;
   localparam logic [4:0]  OTS_SEL_FREQ_LVL1  = 5'h03;
   localparam logic [4:0]  OTS_SEL_FREQ_REACH = 5'h04;
   localparam logic [4:0]  OTS_SEL_ZERO_SPEED = 5'h05;
   localparam logic [4:0]  OTS_SEL_MOTOR_OVL  = 5'h06;
   localparam logic [4:0]  OTS_SEL_DRIVE_OVL  = 5'h07;
   localparam logic [4:0]  OTS_SEL_SET_COUNT  = 5'h08;
   localparam logic [4:0]  OTS_SEL_DSG_COUNT  = 5'h09;
   localparam logic [4:0]  OTS_SEL_LENGTH     = 5'h0A;
   localparam logic [4:0]  OTS_SEL_SEQ_DONE   = 5'h0B;
   localparam logic [4:0]  OTS_SEL_RUN_TIME   = 5'h0C;
   localparam logic [4:0]  OTS_SEL_FREQ_LIM   = 5'h0D;
   localparam logic [4:0]  OTS_SEL_TORQ_LIM   = 5'h0E;
   localparam logic [4:0]  OTS_SEL_READY      = 5'h0F;
   localparam logic [4:0]  OTS_SEL_AIN_CMP    = 5'h10;
   localparam logic [4:0]  OTS_SEL_UPPER_LIM  = 5'h11;
   localparam logic [4:0]  OTS_SEL_LOWER_LIM  = 5'h12;
   localparam logic [4:0]  OTS_SEL_LAST       = 5'h12;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0]  OTS_REG_SEL0       = 8'h00;
   localparam logic [7:0]  OTS_REG_SEL_LAST   = 8'h10;
   localparam logic [7:0]  OTS_REG_TERM_STAT  = 8'h14;
   localparam logic [7:0]  OTS_REG_SET_COUNT  = 8'h18;
   localparam logic [7:0]  OTS_REG_DSG_COUNT  = 8'h1C;
   localparam logic [7:0]  OTS_REG_LENGTH     = 8'h20;
   localparam logic [7:0]  OTS_REG_RUN_TIME   = 8'h24;
   localparam logic [7:0]  OTS_REG_COND_STAT  = 8'h28;
   localparam int          OTS_REG_IDX_LSB    = 2;

   // ------------------------------------------------------------
   // Reset values of the five selection codes and the thresholds
   // ------------------------------------------------------------
   localparam logic [24:0] OTS_SEL_RESET      = {5'h04, 5'h01, 5'h00,
                                                 5'h02, 5'h00};
   localparam logic [31:0] OTS_THR_RESET      = 32'h0000_0000;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int          OTS_CLK_HZ         = 100_000_000;
   localparam int          OTS_PULSE_MS       = 250;
   localparam int          OTS_PULSE_CYC      = OTS_PULSE_MS
                                                * (OTS_CLK_HZ / 1000);
   localparam int          OTS_OVL_LEAD_S     = 10;
   localparam int          OTS_OVL_LEAD_MS    = OTS_OVL_LEAD_S * 1000;

endpackage : ots_pkg

/* ots_term_select.sv */
`timescale 1ns/100ps
// Summary of operation
// - Five terminals, each with its own code, follow their own condition.
// - Code zero gives no function; terminal stays inactive.
// - Code one: ON while drive runs with output, zero frequency included.
// - Code two: ON when drive has stopped because of a fault.
// - Code three: follow first frequency-level detector result.
// - Code four: follow frequency-reached detector result.
// - Code five: ON while running at zero frequency; OFF when stopped.
// - Code six: ON when motor load exceeds overload pre-warning threshold.
// - Code seven: ON ten seconds before drive overload protection trips.
// - Code eight: ON once counter reaches the set count.
// - Code nine: ON once counter reaches the designated count.
// - Code ten: ON when actual length exceeds target length.
// - Code eleven: 250 ms pulse after a finished sequencer cycle; a new finish restarts it.
// - Code twelve: ON when accumulated run time exceeds its threshold.
// - Code thirteen: ON when command beyond a limit and output reached it.
// - Code fourteen: speed mode torque limit gives ON and stall protection.
// - Code fifteen: ON when circuits stable, no fault, ready to run.
// - Code sixteen: ON while first analog input exceeds the second.
// - Code seventeen: ON when running frequency reaches upper limit.
// - Code eighteen: ON at lower limit; forced OFF while stopped.
module ots_term_select
   import ots_pkg::*;
#(
   parameter logic [OTS_PULSE_W-1:0] PULSE_CYCLES =
      OTS_PULSE_W'(OTS_PULSE_CYC)
)(
   // Clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  sys_rst,
   // Wishbone slave
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [OTS_ADR_W-1:0]  wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [OTS_DAT_W-1:0]  wb_dat_i,
   output logic      [OTS_DAT_W-1:0]  wb_dat_o,
   output logic                       wb_ack_o,
   // Drive state
   input  wire logic                  drive_running,
   input  wire logic                  fault_stopped,
   input  wire logic                  out_freq_zero,
   input  wire logic                  main_circuit_stable,
   input  wire logic                  ctrl_circuit_stable,
   input  wire logic                  fault_detected,
   input  wire logic                  run_ready,
   // Frequency and torque detectors
   input  wire logic                  freq_level_detect_1,
   input  wire logic                  freq_reached,
   input  wire logic                  set_freq_beyond_limit,
   input  wire logic                  out_freq_at_limit,
   input  wire logic                  run_freq_at_upper,
   input  wire logic                  run_freq_at_lower,
   input  wire logic                  speed_ctrl_mode,
   input  wire logic                  torque_at_limit,
   // Overload
   input  wire logic                  motor_ovl_prewarn,
   input  wire logic                  drive_ovl_active,
   input  wire logic [31:0]           drive_ovl_trip_ms,
   // Counters, length, time, sequencer, analog
   input  wire logic [31:0]           count_value,
   input  wire logic [31:0]           actual_length,
   input  wire logic [31:0]           accumulated_run_time,
   input  wire logic                  step_sequencer_done,
   input  wire logic [OTS_AIN_W-1:0]  analog_input_1,
   input  wire logic [OTS_AIN_W-1:0]  analog_input_2,
   // Terminals and protection
   output logic [OTS_NUM_TERM-1:0]    term_on,
   output logic                       stall_protect
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [OTS_NUM_TERM-1:0][OTS_CODE_W-1:0] code;
      logic [31:0]                             set_count_threshold;
      logic [31:0]                             designated_count_threshold;
      logic [31:0]                             target_length_setting;
      logic [31:0]                             accumulated_run_time_threshold;
      logic [OTS_PULSE_W-1:0]                  pulse_left;
      logic [OTS_NUM_COND-1:0]                 cond;
      logic [OTS_NUM_TERM-1:0]                 term;
      logic                                    stall;
      logic                                    ack;
      logic [OTS_DAT_W-1:0]                    rdata;
   } ots_state_t;

   ots_state_t st;
   ots_state_t next_st;

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   // Byte-lane merge for a 32-bit write
   function automatic logic [31:0] ots_merge(
      input logic [31:0] old_val,
      input logic [31:0] new_val,
      input logic [3:0]  lanes
   );
      logic [31:0] res;
      res = old_val;
      for (int b = 0; b < 4; b++) begin
         if (lanes[b]) begin
            res[b*8 +: 8] = new_val[b*8 +: 8];
         end
      end
      return res;
   endfunction : ots_merge

   // Condition picked by one selection code
   function automatic logic ots_pick(
      input logic [OTS_CODE_W-1:0]   code,
      input logic [OTS_NUM_COND-1:0] cond
   );
      logic res;
      res = 1'b0;
      if (code != OTS_SEL_NONE && code <= OTS_SEL_LAST) begin
         res = cond[code];
      end
      return res;
   endfunction : ots_pick

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   logic                   bus_req;
   logic [OTS_ADR_W-1:0]   adr;
   logic [OTS_NUM_COND-1:0] c;
   int                     idx;

   always_comb begin
      next_st = st;
      bus_req = wb_cyc_i & wb_stb_i & ~st.ack;
      adr     = wb_adr_i;
      c       = '0;
      idx     = 0;

      // Sequencer pulse; a new cycle end restarts the full width
      if (step_sequencer_done) begin
         next_st.pulse_left = PULSE_CYCLES;
      end else if (st.pulse_left != '0) begin
         next_st.pulse_left = st.pulse_left - 1'b1;
      end

      c[OTS_SEL_NONE]       = 1'b0;
      c[OTS_SEL_RUNNING]    = drive_running;
      c[OTS_SEL_FAULT_STOP] = fault_stopped;
      c[OTS_SEL_FREQ_LVL1]  = freq_level_detect_1;
      c[OTS_SEL_FREQ_REACH] = freq_reached;
      c[OTS_SEL_ZERO_SPEED] = drive_running & out_freq_zero;
      c[OTS_SEL_MOTOR_OVL]  = motor_ovl_prewarn;
      c[OTS_SEL_DRIVE_OVL]  = drive_ovl_active
                              & (drive_ovl_trip_ms
                                 <= 32'(OTS_OVL_LEAD_MS));
      c[OTS_SEL_SET_COUNT]  = count_value
                              >= st.set_count_threshold;
      c[OTS_SEL_DSG_COUNT]  = count_value
                              >= st.designated_count_threshold;
      c[OTS_SEL_LENGTH]     = actual_length
                              > st.target_length_setting;
      c[OTS_SEL_SEQ_DONE]   = st.pulse_left != '0;
      c[OTS_SEL_RUN_TIME]   = accumulated_run_time
                              > st.accumulated_run_time_threshold;
      c[OTS_SEL_FREQ_LIM]   = set_freq_beyond_limit
                              & out_freq_at_limit;
      c[OTS_SEL_TORQ_LIM]   = speed_ctrl_mode & torque_at_limit;
      c[OTS_SEL_READY]      = main_circuit_stable & ctrl_circuit_stable
                              & ~fault_detected & run_ready;
      c[OTS_SEL_AIN_CMP]    = analog_input_1 > analog_input_2;
      c[OTS_SEL_UPPER_LIM]  = run_freq_at_upper;
      c[OTS_SEL_LOWER_LIM]  = run_freq_at_lower & drive_running;
      next_st.cond  = c;
      next_st.stall = c[OTS_SEL_TORQ_LIM];

      // Each terminal reads only its own code
      for (int t = 0; t < OTS_NUM_TERM; t++) begin
         next_st.term[t] = ots_pick(st.code[t], c);
      end

      // Wishbone: ack one cycle after request, dropped the cycle after
      next_st.ack   = bus_req;
      next_st.rdata = '0;
      if (bus_req) begin
         if (adr >= OTS_REG_SEL0 && adr <= OTS_REG_SEL_LAST
             && adr[1:0] == 2'b00) begin
            idx = int'(adr[OTS_ADR_W-1:OTS_REG_IDX_LSB]);
            next_st.rdata = {27'h0, st.code[idx]};
            if (wb_we_i && wb_sel_i[0]) begin
               next_st.code[idx] = wb_dat_i[OTS_CODE_W-1:0];
            end
         end else if (adr == OTS_REG_TERM_STAT) begin
            next_st.rdata = {27'h0, st.term};
         end else if (adr == OTS_REG_SET_COUNT) begin
            next_st.rdata = st.set_count_threshold;
            if (wb_we_i) begin
               next_st.set_count_threshold =
                  ots_merge(st.set_count_threshold, wb_dat_i, wb_sel_i);
            end
         end else if (adr == OTS_REG_DSG_COUNT) begin
            next_st.rdata = st.designated_count_threshold;
            if (wb_we_i) begin
               next_st.designated_count_threshold =
                  ots_merge(st.designated_count_threshold, wb_dat_i,
                            wb_sel_i);
            end
         end else if (adr == OTS_REG_LENGTH) begin
            next_st.rdata = st.target_length_setting;
            if (wb_we_i) begin
               next_st.target_length_setting =
                  ots_merge(st.target_length_setting, wb_dat_i, wb_sel_i);
            end
         end else if (adr == OTS_REG_RUN_TIME) begin
            next_st.rdata = st.accumulated_run_time_threshold;
            if (wb_we_i) begin
               next_st.accumulated_run_time_threshold =
                  ots_merge(st.accumulated_run_time_threshold, wb_dat_i,
                            wb_sel_i);
            end
         end else if (adr == OTS_REG_COND_STAT) begin
            next_st.rdata = {13'h0, st.cond};
         end else begin
            // Unmapped: acked, reads zero, writes dropped
            next_st.rdata = '0;
         end
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st.code                           <= OTS_SEL_RESET;
         st.set_count_threshold            <= OTS_THR_RESET;
         st.designated_count_threshold     <= OTS_THR_RESET;
         st.target_length_setting          <= OTS_THR_RESET;
         st.accumulated_run_time_threshold <= OTS_THR_RESET;
         st.pulse_left                     <= '0;
         st.cond                           <= '0;
         st.term                           <= '0;
         st.stall                          <= 1'b0;
         st.ack                            <= 1'b0;
         st.rdata                          <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // Outputs, all straight from flops
   // ------------------------------------------------------------
   assign term_on       = st.term;
   assign stall_protect = st.stall;
   assign wb_ack_o      = st.ack;
   assign wb_dat_o      = st.rdata;

endmodule : ots_term_select

/* ots_term_select_assertions.sv */
`timescale 1ns/100ps
module ots_term_select_assertions
   import ots_pkg::*;
(
   // Clock, reset, bus
   input wire logic                 core_clk,
   input wire logic                 sys_rst,
   input wire logic                 wb_cyc_i,
   input wire logic                 wb_stb_i,
   input wire logic                 wb_we_i,
   input wire logic [OTS_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0]           wb_sel_i,
   input wire logic [OTS_DAT_W-1:0] wb_dat_i,
   input wire logic                 wb_ack_o,
   // Conditions
   input wire logic                 drive_running,
   input wire logic                 fault_stopped,
   input wire logic                 out_freq_zero,
   input wire logic                 run_freq_at_lower,
   input wire logic                 speed_ctrl_mode,
   input wire logic                 torque_at_limit,
   input wire logic [OTS_AIN_W-1:0] analog_input_1,
   input wire logic [OTS_AIN_W-1:0] analog_input_2,
   // Outputs
   input wire logic [OTS_NUM_TERM-1:0] term_on,
   input wire logic                 stall_protect
);
   // --------------------------------------------------------------
   // Shadow of terminal 0 code, delayed to line up with term_on
   // --------------------------------------------------------------
   logic [4:0] code0;
   logic [4:0] c0;
   logic [1:0] vld;
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         code0 <= 5'h00;
         c0    <= 5'h00;
         vld   <= 2'h0;
      end else begin
         c0  <= code0;
         vld <= {vld[0], 1'b1};
         if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
             && wb_adr_i == 8'h00)
            code0 <= wb_dat_i[4:0];
      end
   end
   // Two edges of pipeline must pass before inputs are trusted
   wire ok = vld[1];

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   // --------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------
   a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("ack missing after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_stall_track: assert property (vld[0] |-> stall_protect ==
      $past(speed_ctrl_mode && torque_at_limit))
      else $error("stall flag wrong");
   a_code_none: assert property (ok && c0 == 5'h00 |-> !term_on[0])
      else $error("code 0 terminal active");
   // Terminal is registered one edge after the inputs it selects
   a_code_run: assert property (ok && c0 == 5'h01 |->
      term_on[0] == $past(drive_running)) else $error("run code");
   a_code_fault: assert property (ok && c0 == 5'h02 |->
      term_on[0] == $past(fault_stopped)) else $error("fault code");
   a_code_zero: assert property (ok && c0 == 5'h05 |->
      term_on[0] == $past(drive_running && out_freq_zero))
      else $error("zero speed code");
   a_code_ain: assert property (ok && c0 == 5'h10 |->
      term_on[0] == $past(analog_input_1 > analog_input_2))
      else $error("analog compare code");
   a_code_lower: assert property (ok && c0 == 5'h12 |->
      term_on[0] == $past(run_freq_at_lower && drive_running))
      else $error("lower limit code");
   a_code_rsvd: assert property (ok && c0 > 5'h12 |-> !term_on[0])
      else $error("reserved code active");
   a_pulse_hold: assert property (ok && c0 == 5'h0B
      && $rose(term_on[0]) |-> term_on[0][*8])
      else $error("pulse too short");
   c_pulse: cover property (ok && c0 == 5'h0B && $rose(term_on[0]));
   c_read: cover property (wb_ack_o && !wb_we_i);
   c_stall: cover property (stall_protect);
endmodule : ots_term_select_assertions

bind ots_term_select ots_term_select_assertions u_chk (
   .core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
   .drive_running(drive_running), .fault_stopped(fault_stopped),
   .out_freq_zero(out_freq_zero), .run_freq_at_lower(run_freq_at_lower),
   .speed_ctrl_mode(speed_ctrl_mode), .torque_at_limit(torque_at_limit),
   .analog_input_1(analog_input_1), .analog_input_2(analog_input_2),
   .term_on(term_on), .stall_protect(stall_protect));

/* ots_load_model.sv */
`timescale 1ns/100ps
module ots_load_model (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   // Terminal seen by the load
   input  wire logic        lamp,
   output logic      [15:0] width
);
   logic [15:0] run;
   // Width latched on the falling edge only, so a retrigger shows as one
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         run   <= 16'h0000;
         width <= 16'h0000;
      end else if (lamp) begin
         run <= run + 16'h0001;
      end else if (run != 16'h0000) begin
         width <= run;
         run   <= 16'h0000;
      end
   end
endmodule : ots_load_model

/* test_ots_term_select.sv */
`timescale 1ns/100ps
module test_ots_term_select;
   import ots_pkg::*;
   logic core_clk = 1'b0, sys_rst = 1'b1, done = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, cnt = 32'h0, len = 32'h0;
   logic [31:0] rtm = 32'h0, trip = 32'h0, thr [4];
   logic [16:0] st = 17'h0;
   logic [11:0] a1 = 12'h000, a2 = 12'h000;
   logic [4:0] term_on, e;
   logic wb_ack_o, stall_protect;
   logic [15:0] width;
   logic [31:0] exp_q [$];
   int error_cnt = 0, cmp_count = 0, n;

   always #5 core_clk = ~core_clk;

   ots_term_select #(.PULSE_CYCLES(25'd10)) u_ots_term_select (
      .core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .drive_running(st[0]), .fault_stopped(st[1]),
      .out_freq_zero(st[2]), .main_circuit_stable(st[3]),
      .ctrl_circuit_stable(st[4]), .fault_detected(st[5]),
      .run_ready(st[6]), .freq_level_detect_1(st[7]),
      .freq_reached(st[8]), .set_freq_beyond_limit(st[9]),
      .out_freq_at_limit(st[10]), .run_freq_at_upper(st[11]),
      .run_freq_at_lower(st[12]), .speed_ctrl_mode(st[13]),
      .torque_at_limit(st[14]), .motor_ovl_prewarn(st[15]),
      .drive_ovl_active(st[16]), .drive_ovl_trip_ms(trip),
      .count_value(cnt), .actual_length(len),
      .accumulated_run_time(rtm), .step_sequencer_done(done),
      .analog_input_1(a1), .analog_input_2(a2), .term_on(term_on),
      .stall_protect(stall_protect));
   ots_load_model u_ots_load_model (.core_clk(core_clk),
      .sys_rst(sys_rst), .lamp(term_on[0]), .width(width));

   task automatic check(input string nm, input logic [31:0] s, x);
      cmp_count++;
      if (s !== x) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, x, s);
      end
   endtask : check

   // A read carries its expected value in d; the monitor compares it
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      if (!w) exp_q.push_back(d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      k = 0;
      do begin @(posedge core_clk); k++; end
      while (wb_ack_o !== 1'b1 && k < 20);
      if (k >= 20) error_cnt++;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge core_clk);
   endtask : wb

   always @(posedge core_clk)
      if (wb_ack_o === 1'b1 && !wb_we_i && exp_q.size() > 0)
         check("rdata", wb_dat_o, exp_q.pop_front());

   function automatic logic exp_cond(input logic [4:0] c);
      logic [18:0] v;
      v = {st[12] & st[0], st[11], a1 > a2, &st[4:3] & ~st[5] & st[6],
           st[13] & st[14], st[9] & st[10], rtm > thr[3], 1'b0,
           len > thr[2], cnt >= thr[1], cnt >= thr[0],
           st[16] && trip <= 32'd10000, st[15], st[0] & st[2], st[8],
           st[7], st[1], st[0], 1'b0};
      return (c <= 5'h12) ? v[c] : 1'b0;
   endfunction : exp_cond

   task automatic report_and_stop;
      $display("Comparisons %0d, errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : report_and_stop

   initial begin
      #200_000;
      error_cnt++;
      report_and_stop();
   end

   initial begin
      void'($urandom(42));
      repeat (4) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      // -----------------------------------------------------------
      // Reset values, unmapped place, threshold setup
      // -----------------------------------------------------------
      for (int t = 0; t < 5; t++)
         wb(1'b0, 8'(4 * t), 32'(OTS_SEL_RESET[5 * t +: 5]));
      wb(1'b0, 8'h3C, 32'h0);
      wb(1'b1, 8'h3C, 32'hFFFF_FFFF);
      wb(1'b0, 8'h18, 32'h0);
      // Code write without the low byte lane must be refused
      wb_sel_i <= 4'hE;
      wb(1'b1, 8'h00, 32'h1F);
      wb_sel_i <= 4'hF;
      wb(1'b0, 8'h00, 32'(OTS_SEL_RESET[4:0]));
      for (int k = 0; k < 4; k++) begin
         thr[k] = (k == 1) ? thr[0] + 32'd1 : $urandom;
         wb(1'b1, 8'(8'h18 + 4 * k), thr[k]);
      end
      // -----------------------------------------------------------
      // Codes 0 to 23 on every terminal, random conditions
      // -----------------------------------------------------------
      for (int i = 0; i < 48; i++) begin
         st   <= 17'($urandom);
         a1   <= 12'($urandom_range(0, 3));
         a2   <= 12'($urandom_range(0, 3));
         cnt  <= thr[0] + 32'($urandom_range(0, 2)) - 32'd1;
         len  <= thr[2] + 32'($urandom_range(0, 2)) - 32'd1;
         rtm  <= thr[3] + 32'($urandom_range(0, 2)) - 32'd1;
         trip <= 32'd9999 + 32'($urandom_range(0, 2));
         for (int t = 0; t < 5; t++)
            wb(1'b1, 8'(4 * t), 32'((i + 5 * t) % 24));
         repeat (3) @(posedge core_clk);
         for (int t = 0; t < 5; t++)
            e[t] = exp_cond(5'((i + 5 * t) % 24));
         check("term_on", 32'(term_on), 32'(e));
         check("stall", 32'(stall_protect), 32'(st[13] & st[14]));
         wb(1'b0, OTS_REG_TERM_STAT, 32'(e));
      end
      // -----------------------------------------------------------
      // Sequencer pulse, single then retriggered
      // -----------------------------------------------------------
      wb(1'b1, 8'h00, 32'h0B);
      for (int r = 0; r < 2; r++) begin
         done <= 1'b1;
         @(posedge core_clk);
         done <= 1'b0;
         if (r == 1) begin
            repeat (4) @(posedge core_clk);
            done <= 1'b1;
            @(posedge core_clk);
            done <= 1'b0;
         end
         n = 0;
         do begin @(posedge core_clk); n++; end
         while (term_on[0] !== 1'b1 && n < 10);
         n = 0;
         do begin @(posedge core_clk); n++; end
         while (term_on[0] !== 1'b0 && n < 40);
         @(posedge core_clk);
         check("width", 32'(width), r ? 32'd15 : 32'd10);
      end
      report_and_stop();
   end
endmodule : test_ots_term_select
